// ==== core/iops_scanner.sv ====
// i/o request and monitor latches with two-tier priority scanner
// Operation
// RULE_01: first tier ranks clock update, then interrupt, function, output/input.
// RULE_02: output and input ranks swap each time either is serviced.
// RULE_03: second tier ranks faults, clock, sync, then channel monitors, input last.
// RULE_04: first-tier channel events are scanned highest channel down to zero.
// RULE_05: channel number outranks event rank among channel events.
// RULE_06: only the best first-tier event is serviced, then scan restarts.
// RULE_07: second-tier monitor events are scanned highest channel down to zero.
// RULE_08: after the second tier, serviced or empty, scan restarts at first tier.
// RULE_09: data and function transfers need an active channel unless intercomputer.
// RULE_10: each channel latches four request kinds, one of each until serviced.
// RULE_11: each channel latches four monitor kinds until serviced.
// RULE_12: winning function and channel form the control-memory address.
// RULE_13: winner's eighteen-bit input word is gated in only after winning.
// RULE_14: acknowledges: input for interrupt or input, output, function.
// RULE_15: peripheral holds its input word until acknowledged.
// RULE_16: second tier is scanned only after a pass finds no first-tier event.
// RULE_17: general lockout holds all but program fault pending; the code holds second-tier events only, first-tier requests are still serviced.
// RULE_18: interrupt lockout keeps interrupt monitors out of the scan.
// RULE_19: sixteen channels; reset clears latches and restores output-first order.
`timescale 1ns/1ps
module iops_scanner
    import iops_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire logic [7:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic [NCH-1:0]    external_interrupt_req,
    input  wire logic [NCH-1:0]    ext_function_req,
    input  wire logic [NCH-1:0]    out_req,
    input  wire logic [NCH-1:0]    in_req,
    input  wire logic [NCH*DW-1:0] in_word,
    input  wire logic [NCH-1:0]    mon_ei,
    input  wire logic [NCH-1:0]    mon_ef,
    input  wire logic [NCH-1:0]    mon_out,
    input  wire logic [NCH-1:0]    mon_in,
    input  wire logic [NSP-1:0]    special_event,
    input  wire logic              rtc_tick,
    output logic                   grant_valid,
    output logic      [AW-1:0]     grant_addr,
    output logic      [DW-1:0]     grant_word,
    output logic      [NCH-1:0]    ack_in,
    output logic      [NCH-1:0]    ack_out,
    output logic      [NCH-1:0]    ack_ef,
    output logic                   irq
);
    iops_state_e    state;
    logic [CTW-1:0] ctrl;
    logic [NCH-1:0] active;
    logic [STW-1:0] status, irq_en;
    logic           out_first;
    logic [NCH-1:0] ei_p, ef_p, out_p, in_p;      // latched requests
    logic [NCH-1:0] eim_p, efm_p, om_p, im_p;     // latched monitors
    logic [NSP-1:0] sp_p;
    logic           rtc_p;
    logic [NCH-1:0] s1 [4];
    logic [NCH-1:0] s2 [4];
    logic [NCH-1:0] s3 [4];
    logic [NCH-1:0] lvl [4];
    logic [NCH-1:0] rise [4];
    logic           a_hit, b_hit;
    logic [FNW-1:0] a_fn, b_fn, w_fn;
    logic [CHW-1:0] a_ch, b_ch, w_ch;
    logic           take;
    logic [NCH-1:0] ch_onehot, chan_ok;
    logic           gen_lock, ei_lock, ic_mode;
    logic           dropped;
    logic           bus_go;

    assign gen_lock = ctrl[CT_GEN_LOCK];
    assign ei_lock  = ctrl[CT_EI_LOCK];
    assign ic_mode  = ctrl[CT_IC];
    assign chan_ok  = active | {NCH{ic_mode}};   // RULE_09

    // request pins pass three flops; a rise counts once stages two and three agree
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int k = 0; k < 4; k++) begin
                s1[k]  <= '0;
                s2[k]  <= '0;
                s3[k]  <= '0;
                lvl[k] <= '0;
            end
        end else begin
            s1[0] <= external_interrupt_req;
            s1[1] <= ext_function_req;
            s1[2] <= out_req;
            s1[3] <= in_req;
            for (int k = 0; k < 4; k++) begin
                s2[k]  <= s1[k];
                s3[k]  <= s2[k];
                lvl[k] <= (s2[k] & s3[k]) | (lvl[k] & (s2[k] | s3[k]));
            end
        end
    end

    always_comb begin
        for (int k = 0; k < 4; k++) begin
            rise[k] = s2[k] & s3[k] & ~lvl[k];
        end
    end

    // first tier: later channels override earlier, so the highest channel wins
    always_comb begin
        a_hit = 1'b0;
        a_fn  = FN_RTC;
        a_ch  = '0;
        for (int i = 0; i < NCH; i++) begin                 // RULE_04
            if (ei_p[i] | (chan_ok[i] & (ef_p[i] | out_p[i] | in_p[i]))) begin  // RULE_05
                a_hit = 1'b1;
                a_ch  = CHW'(i);
                if (ei_p[i]) begin                          // RULE_01
                    a_fn = FN_EI;
                end else if (ef_p[i]) begin
                    a_fn = FN_EF;
                end else if (out_first) begin               // RULE_02
                    a_fn = out_p[i] ? FN_OUT : FN_IN;
                end else begin
                    a_fn = in_p[i] ? FN_IN : FN_OUT;
                end
            end
        end
        if (rtc_p) begin                                    // RULE_01
            a_hit = 1'b1;
            a_fn  = FN_RTC;
            a_ch  = '0;
        end
    end

    // second tier: lowest rank written first so higher ranks override it
    always_comb begin
        b_hit = 1'b0;
        b_fn  = FN_IM;
        b_ch  = '0;
        if (!gen_lock) begin                                // RULE_17
            for (int i = 0; i < NCH; i++) begin
                if (im_p[i]) begin                          // RULE_03
                    b_hit = 1'b1;
                    b_fn  = FN_IM;
                    b_ch  = CHW'(i);
                end
            end
            for (int i = 0; i < NCH; i++) begin             // RULE_07
                if ((eim_p[i] & ~ei_lock) | efm_p[i] | om_p[i]) begin   // RULE_18
                    b_hit = 1'b1;
                    b_ch  = CHW'(i);
                    if (eim_p[i] & ~ei_lock) begin
                        b_fn = FN_EIM;
                    end else if (efm_p[i]) begin
                        b_fn = FN_EFM;
                    end else begin
                        b_fn = FN_OM;
                    end
                end
            end
            if (sp_p[SP_SYNC] | sp_p[SP_RTCO] | sp_p[SP_RTCM] | sp_p[SP_RFLT]) begin
                b_hit = 1'b1;
                b_ch  = '0;
                if (sp_p[SP_RFLT]) begin                    // RULE_03
                    b_fn = FN_RFLT;
                end else if (sp_p[SP_RTCM]) begin
                    b_fn = FN_RTCM;
                end else if (sp_p[SP_RTCO]) begin
                    b_fn = FN_RTCO;
                end else begin
                    b_fn = FN_SYNC;
                end
            end
        end
        if (sp_p[SP_PFLT]) begin                            // program fault ignores lockout
            b_hit = 1'b1;
            b_fn  = FN_PFLT;
            b_ch  = '0;
        end
    end

    // the winner of the tier being scanned this cycle
    assign take      = (state == ST_SCAN_A) ? a_hit : ((state == ST_SCAN_B) & b_hit);
    assign w_fn      = (state == ST_SCAN_A) ? a_fn : b_fn;
    assign w_ch      = (state == ST_SCAN_A) ? a_ch : b_ch;
    assign ch_onehot = take ? (NCH'(1) << w_ch) : '0;

    // scan sequencer: one service per pass, always restarting at the first tier
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_SCAN_A;
        end else begin
            case (state)
                ST_SCAN_A: state <= a_hit ? ST_SERVE : ST_SCAN_B;   // RULE_16
                ST_SCAN_B: state <= b_hit ? ST_SERVE : ST_SCAN_A;   // RULE_08
                ST_SERVE:  state <= ST_SCAN_A;                      // RULE_06
                default:   state <= ST_SCAN_A;
            endcase
        end
    end

    // request latches; a new rise in the clearing cycle is kept, a rise while pending is lost
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ei_p  <= '0;
            ef_p  <= '0;
            out_p <= '0;
            in_p  <= '0;
            rtc_p <= 1'b0;
        end else begin
            ei_p  <= (ei_p  & ~(ch_onehot & {NCH{w_fn == FN_EI}}))  | rise[0];  // RULE_10
            ef_p  <= (ef_p  & ~(ch_onehot & {NCH{w_fn == FN_EF}}))  | rise[1];
            out_p <= (out_p & ~(ch_onehot & {NCH{w_fn == FN_OUT}})) | rise[2];
            in_p  <= (in_p  & ~(ch_onehot & {NCH{w_fn == FN_IN}}))  | rise[3];
            rtc_p <= (rtc_p & ~(take & (w_fn == FN_RTC))) | rtc_tick;
        end
    end

    // monitor and special latches, held until the scanner services them
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            eim_p <= '0;
            efm_p <= '0;
            om_p  <= '0;
            im_p  <= '0;
            sp_p  <= '0;
        end else begin
            eim_p <= (eim_p & ~(ch_onehot & {NCH{w_fn == FN_EIM}})) | mon_ei;   // RULE_11
            efm_p <= (efm_p & ~(ch_onehot & {NCH{w_fn == FN_EFM}})) | mon_ef;
            om_p  <= (om_p  & ~(ch_onehot & {NCH{w_fn == FN_OM}}))  | mon_out;
            im_p  <= (im_p  & ~(ch_onehot & {NCH{w_fn == FN_IM}}))  | mon_in;
            sp_p[SP_PFLT] <= (sp_p[SP_PFLT] & ~(take & (w_fn == FN_PFLT)))
                             | special_event[SP_PFLT];
            sp_p[SP_RFLT] <= (sp_p[SP_RFLT] & ~(take & (w_fn == FN_RFLT)))
                             | special_event[SP_RFLT];
            sp_p[SP_RTCM] <= (sp_p[SP_RTCM] & ~(take & (w_fn == FN_RTCM)))
                             | special_event[SP_RTCM];
            sp_p[SP_RTCO] <= (sp_p[SP_RTCO] & ~(take & (w_fn == FN_RTCO)))
                             | special_event[SP_RTCO];
            sp_p[SP_SYNC] <= (sp_p[SP_SYNC] & ~(take & (w_fn == FN_SYNC)))
                             | special_event[SP_SYNC];
        end
    end

    // output/input alternation flips on every service of either
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            out_first <= OUT_FIRST_RST;                         // RULE_19
        end else if ((state == ST_SCAN_A) & a_hit & ((a_fn == FN_OUT) | (a_fn == FN_IN))) begin
            out_first <= ~out_first;                            // RULE_02
        end
    end

    // grant valid and acknowledges are one-cycle pulses in the serve state; address and gated word hold until replaced
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            grant_valid <= 1'b0;
            grant_addr  <= '0;
            grant_word  <= '0;
            ack_in      <= '0;
            ack_out     <= '0;
            ack_ef      <= '0;
        end else begin
            grant_valid <= take;
            ack_in  <= ch_onehot & {NCH{(w_fn == FN_IN) | (w_fn == FN_EI)}};   // RULE_14
            ack_out <= ch_onehot & {NCH{w_fn == FN_OUT}};
            ack_ef  <= ch_onehot & {NCH{w_fn == FN_EF}};
            if (take) begin
                grant_addr <= {w_fn, w_ch};                     // RULE_12
            end
            // word pins are steady by now since the peripheral holds them until acknowledged
            if (take & ((w_fn == FN_IN) | (w_fn == FN_EI))) begin
                grant_word <= in_word[w_ch*DW +: DW];           // RULE_13 RULE_15
            end
        end
    end

    assign dropped = |((rise[0] & ei_p) | (rise[1] & ef_p) | (rise[2] & out_p) | (rise[3] & in_p));
    assign bus_go  = (avs_read | avs_write) & ~avs_waitrequest;

    // bus slave: answer one cycle after the request is seen, effect at the release edge
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if (avs_read & avs_waitrequest) begin
                case (avs_address)
                    OFF_CTRL:   avs_readdata <= 32'(ctrl);
                    OFF_ACTIVE: avs_readdata <= 32'(active);
                    OFF_STATUS: avs_readdata <= 32'(status);
                    OFF_ENABLE: avs_readdata <= 32'(irq_en);
                    OFF_SCAN:   avs_readdata <= 32'({out_first, grant_addr});
                    default:    avs_readdata <= 32'h0000_0000;  // unmapped and clear read zero
                endcase
            end
        end
    end

    // software registers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl   <= '0;
            active <= '0;
            irq_en <= '0;
        end else if (bus_go & avs_write) begin
            case (avs_address)
                OFF_CTRL:   ctrl   <= avs_writedata[CTW-1:0];
                OFF_ACTIVE: active <= avs_writedata[NCH-1:0];
                OFF_ENABLE: irq_en <= avs_writedata[STW-1:0];
                default:    ;
            endcase
        end
    end

    // sticky status: a new event wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            status <= '0;
            irq    <= 1'b0;
        end else begin
            status <= (status & ~((bus_go & avs_write & (avs_address == OFF_CLEAR))
                                  ? avs_writedata[STW-1:0] : '0))
                      | {dropped, (state == ST_SCAN_B) & b_hit, (state == ST_SCAN_A) & a_hit};
            irq    <= |(status & irq_en);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    chk_clock_first:  assert property ((state == ST_SCAN_A) & rtc_p |=> grant_addr[AW-1:CHW] == FN_RTC)   // RULE_01
        else $error("clock update did not win first tier");
    chk_alt_swap:     assert property ((state == ST_SCAN_A) & a_hit & ((a_fn == FN_OUT) | (a_fn == FN_IN))
                          |=> out_first != $past(out_first))   // RULE_02
        else $error("output/input order did not swap");
    chk_serve_restart: assert property (state == ST_SERVE |=> state == ST_SCAN_A)   // RULE_06
        else $error("scan did not restart after service");
    chk_b_after_a:    assert property (state == ST_SCAN_B |-> $past(state) == ST_SCAN_A && !$past(a_hit))   // RULE_16
        else $error("second tier entered with first-tier event");
    chk_active_gate:  assert property ((state == ST_SCAN_A) & a_hit & (a_fn != FN_EI) & (a_fn != FN_RTC)
                          |-> chan_ok[a_ch])   // RULE_09
        else $error("transfer granted on inactive channel");
    chk_lock_general: assert property ((state == ST_SCAN_B) & b_hit & gen_lock |-> b_fn == FN_PFLT)   // RULE_17
        else $error("interrupt serviced under lockout");
    chk_lock_ei:      assert property ((state == ST_SCAN_B) & b_hit & ei_lock |-> b_fn != FN_EIM)   // RULE_18
        else $error("interrupt monitor serviced under lockout");
    chk_addr_encode:  assert property (take |=> grant_valid && grant_addr == {$past(w_fn), $past(w_ch)})   // RULE_12
        else $error("control-memory address wrong");
    chk_ack_input:    assert property (grant_valid & (grant_addr[AW-1:CHW] == FN_IN)
                          |-> ack_in[grant_addr[CHW-1:0]] && ack_out == '0)   // RULE_14
        else $error("input acknowledge missing");
    chk_bus_answer:   assert property ((avs_read | avs_write) & avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered in one cycle");

    cov_swap_seen:  cover property ((state == ST_SCAN_A) & a_hit & (a_fn == FN_IN) ##[1:20] (state == ST_SCAN_A) & a_hit & (a_fn == FN_OUT));
    cov_b_service:  cover property ((state == ST_SCAN_B) & b_hit & (b_fn == FN_EIM));
    cov_irq_raised: cover property ($rose(irq));
    cov_pfault_lock: cover property ((state == ST_SCAN_B) & gen_lock & (b_fn == FN_PFLT) & b_hit);
endmodule : iops_scanner

// ==== shared/iops_pkg.sv ====
// constants and types shared by the i/o priority scanner
package iops_pkg;
    localparam int NCH = 16;                  // channels 0..17 octal
    localparam int CHW = 4;                   // channel number width
    localparam int DW  = 18;                  // data word width
    localparam int FNW = 4;                   // function code width
    localparam int AW  = FNW + CHW;           // control-memory address width

    // function codes, upper part of the control-memory address
    localparam logic [FNW-1:0] FN_RTC  = 4'h0;  // real-time clock update
    localparam logic [FNW-1:0] FN_EI   = 4'h1;  // external_interrupt request
    localparam logic [FNW-1:0] FN_EF   = 4'h2;  // ext_function request
    localparam logic [FNW-1:0] FN_OUT  = 4'h3;  // output data request
    localparam logic [FNW-1:0] FN_IN   = 4'h4;  // input data request
    localparam logic [FNW-1:0] FN_PFLT = 4'h5;  // program fault
    localparam logic [FNW-1:0] FN_RFLT = 4'h6;  // resume fault
    localparam logic [FNW-1:0] FN_RTCM = 4'h7;  // clock monitor
    localparam logic [FNW-1:0] FN_RTCO = 4'h8;  // clock overflow
    localparam logic [FNW-1:0] FN_SYNC = 4'h9;  // synchronizing interrupt
    localparam logic [FNW-1:0] FN_EIM  = 4'hA;  // external_interrupt monitor
    localparam logic [FNW-1:0] FN_EFM  = 4'hB;  // ext_function monitor
    localparam logic [FNW-1:0] FN_OM   = 4'hC;  // output monitor
    localparam logic [FNW-1:0] FN_IM   = 4'hD;  // input monitor

    // special interrupt input bit positions
    localparam int SP_PFLT = 0;
    localparam int SP_RFLT = 1;
    localparam int SP_RTCM = 2;
    localparam int SP_RTCO = 3;
    localparam int SP_SYNC = 4;
    localparam int NSP     = 5;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_ACTIVE = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_CLEAR  = 8'h0C;
    localparam logic [7:0] OFF_ENABLE = 8'h10;
    localparam logic [7:0] OFF_SCAN   = 8'h14;

    // control register fields
    localparam int CT_GEN_LOCK = 0;
    localparam int CT_EI_LOCK  = 1;
    localparam int CT_IC       = 2;
    localparam int CTW         = 3;

    // status / enable / clear fields
    localparam int ST_A_DONE = 0;             // first-tier event serviced
    localparam int ST_B_DONE = 1;             // second-tier event serviced
    localparam int ST_DROP   = 2;             // request refused while pending
    localparam int STW       = 3;

    localparam logic OUT_FIRST_RST = 1'b1;    // output outranks input after reset

    typedef enum logic [2:0] {
        ST_SCAN_A = 3'b001,
        ST_SCAN_B = 3'b010,
        ST_SERVE  = 3'b100
    } iops_state_e;
endpackage : iops_pkg

// ==== test/iops_periph.sv ====
// peripheral side model: request lines per channel and their held input words
`timescale 1ns/1ps
module iops_periph
    import iops_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire logic [NCH-1:0]    raise_ei,
    input  wire logic [NCH-1:0]    raise_ef,
    input  wire logic [NCH-1:0]    raise_out,
    input  wire logic [NCH-1:0]    raise_in,
    input  wire logic [NCH-1:0]    ack_in,
    input  wire logic [NCH-1:0]    ack_out,
    input  wire logic [NCH-1:0]    ack_ef,
    output logic      [NCH-1:0]    external_interrupt_req,
    output logic      [NCH-1:0]    ext_function_req,
    output logic      [NCH-1:0]    out_req,
    output logic      [NCH-1:0]    in_req,
    output logic      [NCH*DW-1:0] in_word
);
    // a request stands until its acknowledge comes back
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            external_interrupt_req <= '0;
            ext_function_req       <= '0;
            out_req                <= '0;
            in_req                 <= '0;
        end else begin
            external_interrupt_req <= (external_interrupt_req & ~ack_in) | raise_ei;
            ext_function_req       <= (ext_function_req & ~ack_ef) | raise_ef;
            out_req                <= (out_req & ~ack_out) | raise_out;
            // one input acknowledge retires the interrupt first, the input word next
            in_req                 <= (in_req & ~(ack_in & ~external_interrupt_req)) | raise_in;
        end
    end

    // word held while an input-type request waits; inverted once released so stale data shows
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            in_word[c*DW +: DW] = (in_req[c] | external_interrupt_req[c]) ?
                {14'h2A55, 4'(c)} : ~{14'h2A55, 4'(c)};
        end
    end
endmodule : iops_periph

// ==== test/tb_io_priority_scanner.sv ====
// self-checking bench for the i/o priority scanner
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
    $display("ERROR %0t got %h expected %h", $time, (a), (e)); end end
module tb_io_priority_scanner;
    import iops_pkg::*;
    logic              core_clk, rstn, avs_read, avs_write, avs_waitrequest, rtc_tick;
    logic              grant_valid, irq;
    logic [7:0]        avs_address;
    logic [31:0]       avs_writedata, avs_readdata, q;
    logic [NCH-1:0]    ei, ef, orq, irq_in, r_ei, r_ef, r_out, r_in, ack_in, ack_out, ack_ef;
    logic [NCH-1:0]    mon_ei, mon_ef, mon_out, mon_in;
    logic [NCH*DW-1:0] in_word;
    logic [NSP-1:0]    special_event;
    logic [AW-1:0]     grant_addr;
    logic [DW-1:0]     grant_word;
    logic [AW-1:0]     seq [7] = '{8'h60, 8'h70, 8'h80, 8'h90, 8'hCC, 8'hB9, 8'hDF};
    int                fails, checked, cyc;

    iops_scanner dut (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .external_interrupt_req(ei), .ext_function_req(ef), .out_req(orq), .in_req(irq_in),
        .in_word(in_word), .mon_ei(mon_ei), .mon_ef(mon_ef), .mon_out(mon_out),
        .mon_in(mon_in), .special_event(special_event), .rtc_tick(rtc_tick),
        .grant_valid(grant_valid), .grant_addr(grant_addr), .grant_word(grant_word),
        .ack_in(ack_in), .ack_out(ack_out), .ack_ef(ack_ef), .irq(irq));
    iops_periph periph (.core_clk(core_clk), .rstn(rstn), .raise_ei(r_ei), .raise_ef(r_ef),
        .raise_out(r_out), .raise_in(r_in), .ack_in(ack_in), .ack_out(ack_out),
        .ack_ef(ack_ef), .external_interrupt_req(ei), .ext_function_req(ef),
        .out_req(orq), .in_req(irq_in), .in_word(in_word));

    function automatic logic [DW-1:0] pw(input logic [3:0] c);
        return {14'h2A55, c};
    endfunction : pw

    // one bus access; the request stands until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin @(posedge core_clk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        `CHK(avs_waitrequest, 1'b0)
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // let an edge pass so a following access never re-drives a strobe in this step
        @(posedge core_clk);
    endtask : bus

    // pulse the peripheral raise lines for one cycle
    task automatic raise(input logic [NCH-1:0] a, b, c, d);
        r_ei <= a;
        r_ef <= b;
        r_out <= c;
        r_in <= d;
        @(posedge core_clk);
        r_ei <= '0;
        r_ef <= '0;
        r_out <= '0;
        r_in <= '0;
    endtask : raise

    // wait for the next service and judge address, acknowledges and word (k: 0 in,1 out,2 fn,3 none)
    task automatic grant(input logic [AW-1:0] a, input int k);
        logic [47:0] e;
        int n;
        e = (k < 3) ? (48'(16'h1 << a[3:0]) << (16 * k)) : 48'h0;
        n = 0;
        do begin @(posedge core_clk); n++; end while (grant_valid !== 1'b1 && n < 40);
        `CHK(grant_valid, 1'b1)
        `CHK(grant_addr, a)
        `CHK({ack_ef, ack_out, ack_in}, e)
        if (k == 0) `CHK(grant_word, pw(a[3:0]))
    endtask : grant

    task automatic quiet(input int n);
        repeat (n) begin @(posedge core_clk); `CHK(grant_valid, 1'b0) end
    endtask : quiet

    task automatic t_first;
        bus(1, OFF_ACTIVE, 32'h0);
        raise(16'h0, 16'h0008, 16'h0008, 16'h0004);
        quiet(10);
        rtc_tick <= 1'b1;
        @(posedge core_clk);
        rtc_tick <= 1'b0;
        grant({FN_RTC, 4'h0}, 3);
        raise(16'h0004, 16'h0, 16'h0, 16'h0);
        grant({FN_EI, 4'h2}, 0);
        bus(1, OFF_ACTIVE, 32'hFFFF);
        grant({FN_EF, 4'h3}, 2);
        grant({FN_OUT, 4'h3}, 1);
        grant({FN_IN, 4'h2}, 0);
        bus(0, OFF_SCAN, 32'h0);
        `CHK(q, 32'h142)
        raise(16'h0, 16'h0, 16'h0, 16'h0080);
        grant({FN_IN, 4'h7}, 0);
        raise(16'h0, 16'h0, 16'h0040, 16'h0040);
        grant({FN_IN, 4'h6}, 0);
        grant({FN_OUT, 4'h6}, 1);
        raise(16'h4000, 16'h0, 16'h8000, 16'h0);
        grant({FN_OUT, 4'hF}, 1);
        grant({FN_EI, 4'hE}, 0);
        $display("first tier test done");
    endtask : t_first

    task automatic t_second;
        bus(1, OFF_CTRL, 32'h1);
        special_event <= 5'h1F;
        mon_ei <= 16'h0200;
        mon_ef <= 16'h0200;
        mon_out <= 16'h1000;
        mon_in <= 16'h8000;
        @(posedge core_clk);
        special_event <= '0;
        mon_ei <= '0;
        mon_ef <= '0;
        mon_out <= '0;
        mon_in <= '0;
        grant({FN_PFLT, 4'h0}, 3);
        quiet(8);
        bus(1, OFF_CTRL, 32'h2);
        foreach (seq[j]) grant(seq[j], 3);
        quiet(8);
        bus(1, OFF_CTRL, 32'h0);
        grant({FN_EIM, 4'h9}, 3);
        bus(1, OFF_ACTIVE, 32'h0);
        bus(1, OFF_CTRL, 32'h4);
        raise(16'h0, 16'h0, 16'h0002, 16'h0);
        grant({FN_OUT, 4'h1}, 1);
        $display("second tier test done");
    endtask : t_second

    task automatic t_regs;
        `CHK(irq, 1'b0)
        bus(1, OFF_ENABLE, 32'h3);
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b1)
        bus(0, OFF_STATUS, 32'h0);
        `CHK(q, 32'h3)
        bus(1, OFF_CLEAR, 32'h3);
        bus(0, OFF_CLEAR, 32'h0);
        `CHK(q, 32'h0)
        bus(0, 8'h18, 32'h0);
        `CHK(q, 32'h0)
        bus(0, OFF_STATUS, 32'h0);
        `CHK(q, 32'h0)
        `CHK(irq, 1'b0)
        $display("register test done");
    endtask : t_regs

    task automatic results;
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results

    initial begin
        core_clk = 0;
        forever #10 core_clk = ~core_clk;
    end

    // cut a hang short well past the few hundred cycles the tests need
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 4000) begin fails++; results(); end
    end

    initial begin
        {rstn, avs_read, avs_write, rtc_tick, avs_address, avs_writedata} = '0;
        {r_ei, r_ef, r_out, r_in, mon_ei, mon_ef, mon_out, mon_in, special_event} = '0;
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        bus(0, OFF_SCAN, 32'h0);
        `CHK(q, 32'h100)
        t_first();
        t_second();
        t_regs();
        results();
    end
endmodule : tb_io_priority_scanner
